// file: page_if.sv
// Per-port embedded type settings passed to the packet labeller
`default_nettype none
interface page_if;
    import page_pkg::*;
    logic [7:0] embed_cfg;
    logic       raw_mode;
    logic       frame_start;
    logic       long_pkt;
    logic [5:0] video_type;
    logic [5:0] out_type;
    modport regs   (output embed_cfg, raw_mode, frame_start, long_pkt, video_type, input out_type);
    modport labeller (input embed_cfg, raw_mode, frame_start, long_pkt, video_type, output out_type);
endinterface
`default_nettype wire

// file: page_pkg.sv
// Constants and types for the receive port paging block
`default_nettype none
package page_pkg;
    localparam int unsigned NUM_PORTS         = 4;
    localparam int unsigned NUM_SRC           = 5;   // Local I2C plus one back-channel per port
    localparam logic [7:0]  ADDR_EMBED        = 8'h4B;
    localparam logic [7:0]  ADDR_PAGING       = 8'h4C;
    localparam logic [7:0]  PAGED_LO_A        = 8'h4D;
    localparam logic [7:0]  PAGED_HI_A        = 8'h7F;
    localparam logic [7:0]  PAGED_LO_B        = 8'hD0;
    localparam logic [7:0]  PAGED_HI_B        = 8'hDF;
    localparam logic [7:0]  EMBED_RST         = 8'h12;
    localparam logic [5:0]  EMBED_CODE_RST    = 6'h12;
    localparam int unsigned CONN_MSB          = 7;
    localparam int unsigned CONN_LSB          = 6;
    localparam int unsigned RSEL_MSB          = 5;
    localparam int unsigned RSEL_LSB          = 4;
    localparam int unsigned WEN_MSB           = 3;
    localparam int unsigned CNT_MSB           = 7;
    localparam int unsigned CNT_LSB           = 6;
    localparam int unsigned CODE_MSB          = 5;
    localparam logic [1:0]  LINES_OFF         = 2'h0;
    localparam logic [2:0]  SRC_LOCAL         = 3'h0;
    typedef enum logic [1:0] {
        PKT_IDLE  = 2'b00,
        PKT_FRAME = 2'b01,
        PKT_DONE  = 2'b11
    } pkt_state_t;

    // Ranges of per-port registers
    function automatic logic is_paged(input logic [7:0] a);
        return (a >= PAGED_LO_A && a <= PAGED_HI_A) || (a >= PAGED_LO_B && a <= PAGED_HI_B) || a == ADDR_EMBED;
    endfunction

    // Back-channel source n carries port n-1
    function automatic logic [1:0] src_port(input logic [2:0] s);
        return (s == SRC_LOCAL) ? 2'h0 : 2'(s - 3'h1);
    endfunction
endpackage
`default_nettype wire

// file: page_regs_model.sv
// Per-port register blocks behind the paging logic
`default_nettype none
module page_regs_model (
    input  wire logic [0:0]  sys_clk_i, // Clock
    input  wire logic [3:0]  port_we_i, // Port strobes
    input  wire logic [7:0]  addr_i,    // Offset
    input  wire logic [7:0]  wdata_i,   // Write data
    output logic      [31:0] rdata_o    // Port data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4][256];
    // Known fill so untouched ports can be predicted
    initial for (int p = 0; p < 4; p++) for (int a = 0; a < 256; a++) mem[p][a] = 8'(a ^ p);
    always @(posedge sys_clk_i) for (int p = 0; p < 4; p++) if (port_we_i[p]) mem[p][addr_i] <= wdata_i;
    always_comb for (int p = 0; p < 4; p++) rdata_o[8*p+:8] = mem[p][addr_i];
endmodule
`default_nettype wire

// file: pkt_labeller.sv
// Relabels the first long packets of a raw-mode frame with the embedded type
`default_nettype none
module pkt_labeller
    import page_pkg::*;
(
    input  wire logic sys_clk_i,   // Clock
    input  wire logic sys_rst_i,   // Async reset, high
    page_if.labeller  lnk          // Settings and packet stream
);
    pkt_state_t state_r, state_nxt;
    logic [1:0] seen_r, seen_nxt;
    logic [1:0] lines;
    logic       override;

    always_comb begin
        lines     = lnk.embed_cfg[CNT_MSB:CNT_LSB];
        state_nxt = state_r;
        seen_nxt  = seen_r;
        case (state_r)
            PKT_IDLE,
            PKT_DONE: begin
                if (lnk.frame_start) begin
                    state_nxt = PKT_FRAME;
                    seen_nxt  = 2'h0;
                end
            end
            PKT_FRAME: begin
                if (lnk.frame_start) begin
                    seen_nxt = 2'h0;
                end else if (lnk.long_pkt) begin
                    seen_nxt = seen_r + 2'h1;
                    if (seen_r + 2'h1 >= lines) begin
                        state_nxt = PKT_DONE;
                    end
                end
            end
            default: begin
                state_nxt = PKT_IDLE;
            end
        endcase
        // Count applies from the packet that follows frame start
        override = lnk.raw_mode
                && lines != LINES_OFF
                && state_r == PKT_FRAME && seen_r < lines;
        lnk.out_type = override ? lnk.embed_cfg[CODE_MSB:0] : lnk.video_type;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= PKT_IDLE;
            seen_r  <= 2'h0;
        end else begin
            state_r <= state_nxt;
            seen_r  <= seen_nxt;
        end
    end
endmodule
`default_nettype wire

// file: rx_port_page_select.sv
// Receive port paging and per-port embedded type override
`default_nettype none
module rx_port_page_select
    import page_pkg::*;
#(
    parameter int unsigned PORTS = NUM_PORTS
) (
    input  wire logic                 sys_clk_i,        // Clock
    input  wire logic                 sys_rst_i,        // Async reset, high
    input  wire logic                 acc_valid_i,      // Register access strobe
    input  wire logic                 acc_write_i,      // 1 write, 0 read
    input  wire logic [2:0]           acc_src_i,        // 0 local I2C, 1..4 back-channel port 0..3
    input  wire logic [7:0]           acc_addr_i,       // Register offset
    input  wire logic [7:0]           acc_wdata_i,      // Write data
    input  wire logic [7:0]           shared_rdata_i,   // Read data of shared registers
    input  wire logic [PORTS*8-1:0]   port_rdata_i,     // Read data of other paged registers per port
    output logic                      shared_we_o,      // Write strobe to shared registers
    output logic [PORTS-1:0]          port_we_o,        // Write strobe per port block
    output logic [7:0]                acc_rdata_o,      // Read data, registered
    output logic                      acc_rvalid_o,     // Read data valid
    input  wire logic [PORTS-1:0]     raw_mode_i,       // Port receives raw data
    input  wire logic [PORTS-1:0]     frame_start_i,    // Frame start per port
    input  wire logic [PORTS-1:0]     long_pkt_i,       // Long packet per port
    input  wire logic [PORTS*6-1:0]   video_type_i,     // Normal raw video type per port
    output logic [PORTS*6-1:0]        pkt_type_o        // Data type applied per port
);
    logic [1:0]       rsel_r   [NUM_SRC];
    logic [1:0]       rsel_nxt [NUM_SRC];
    logic [PORTS-1:0] wen_r    [NUM_SRC];
    logic [PORTS-1:0] wen_nxt  [NUM_SRC];
    logic [7:0]       embed_r   [PORTS];
    logic [7:0]       embed_nxt [PORTS];
    logic [7:0]       rdata_r, rdata_nxt;
    logic             rvalid_r, rvalid_nxt;
    logic [1:0]       cur_rsel;
    logic [PORTS-1:0] cur_wen;
    logic             paged;

    // Default paging of a source
    function automatic logic [PORTS-1:0] wen_default(input logic [2:0] s);
        logic [PORTS-1:0] v;
        v = '0;
        if (s != SRC_LOCAL) begin
            v[src_port(s)] = 1'b1;
        end
        return v;
    endfunction

    always_comb begin
        cur_rsel = rsel_r[acc_src_i];
        cur_wen  = wen_r[acc_src_i];
        paged    = is_paged(acc_addr_i);
        for (int s = 0; s < NUM_SRC; s++) begin
            rsel_nxt[s] = rsel_r[s];
            wen_nxt[s]  = wen_r[s];
        end
        for (int p = 0; p < PORTS; p++) begin
            embed_nxt[p] = embed_r[p];
        end
        shared_we_o = 1'b0;
        port_we_o   = '0;
        rvalid_nxt  = acc_valid_i && !acc_write_i;
        rdata_nxt   = rdata_r;
        if (acc_valid_i && acc_write_i) begin
            if (acc_addr_i == ADDR_PAGING) begin
                // Only the issuing source's copy changes
                rsel_nxt[acc_src_i] = acc_wdata_i[RSEL_MSB:RSEL_LSB];
                wen_nxt[acc_src_i]  = acc_wdata_i[WEN_MSB:0];
            end else if (paged) begin
                port_we_o = cur_wen;
                if (acc_addr_i == ADDR_EMBED) begin
                    for (int p = 0; p < PORTS; p++) begin
                        if (cur_wen[p]) begin
                            embed_nxt[p] = acc_wdata_i;
                        end
                    end
                end
            end else begin
                shared_we_o = 1'b1;
            end
        end
        if (acc_valid_i && !acc_write_i) begin
            if (acc_addr_i == ADDR_PAGING) begin
                rdata_nxt = {src_port(acc_src_i), cur_rsel, cur_wen};
            end else if (acc_addr_i == ADDR_EMBED) begin
                rdata_nxt = embed_r[cur_rsel];
            end else if (paged) begin
                rdata_nxt = port_rdata_i[cur_rsel*8 +: 8];
            end else begin
                rdata_nxt = shared_rdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                rsel_r[s] <= src_port(3'(s));
                wen_r[s]  <= wen_default(3'(s));
            end
            for (int p = 0; p < PORTS; p++) begin
                embed_r[p] <= EMBED_RST;
            end
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            for (int s = 0; s < NUM_SRC; s++) begin
                rsel_r[s] <= rsel_nxt[s];
                wen_r[s]  <= wen_nxt[s];
            end
            for (int p = 0; p < PORTS; p++) begin
                embed_r[p] <= embed_nxt[p];
            end
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign acc_rdata_o  = rdata_r;
    assign acc_rvalid_o = rvalid_r;

    // One labeller per receive port
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        page_if lnk ();
        assign lnk.embed_cfg   = embed_r[p];
        assign lnk.raw_mode    = raw_mode_i[p];
        assign lnk.frame_start = frame_start_i[p];
        assign lnk.long_pkt    = long_pkt_i[p];
        assign lnk.video_type  = video_type_i[p*6 +: 6];
        assign pkt_type_o[p*6 +: 6] = lnk.out_type;
        pkt_labeller u_lab (
            .sys_clk_i (sys_clk_i),
            .sys_rst_i (sys_rst_i),
            .lnk       (lnk)
        );
    end
endmodule
`default_nettype wire

// file: rx_port_page_select_chk.sv
// Port assertions for the paging block
`default_nettype none
module rx_port_page_select_chk #(
    parameter int unsigned PORTS = 4
) (
    input wire logic               sys_clk_i,    // Clock
    input wire logic               sys_rst_i,    // Reset
    input wire logic               acc_valid_i,  // Strobe
    input wire logic               acc_write_i,  // Write
    input wire logic [2:0]         acc_src_i,    // Source
    input wire logic [7:0]         acc_addr_i,   // Offset
    input wire logic               shared_we_o,  // Shared
    input wire logic [PORTS-1:0]   port_we_o,    // Ports
    input wire logic [7:0]         acc_rdata_o,  // Data
    input wire logic               acc_rvalid_o, // Valid
    input wire logic [PORTS-1:0]   raw_mode_i,   // Raw
    input wire logic [PORTS*6-1:0] video_type_i, // Normal
    input wire logic [PORTS*6-1:0] pkt_type_o    // Applied
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic rd, wr, pg;
    assign rd = acc_valid_i && !acc_write_i;
    assign wr = acc_valid_i && acc_write_i;
    assign pg = (acc_addr_i >= 8'h4D && acc_addr_i <= 8'h7F) || (acc_addr_i >= 8'hD0 && acc_addr_i <= 8'hDF)
                || acc_addr_i == 8'h4B;
    read_answer_a: assert property (rd |=> acc_rvalid_o) else $error("read not answered");
    idle_quiet_a: assert property (!rd |=> !acc_rvalid_o && $stable(acc_rdata_o)) else $error("stray read");
    shared_write_a: assert property (wr && !pg && acc_addr_i != 8'h4C |-> shared_we_o && port_we_o == '0)
        else $error("shared write misrouted");
    paged_write_a: assert property (wr && pg |-> !shared_we_o) else $error("paged write shared");
    no_write_a: assert property (!wr |-> port_we_o == '0 && !shared_we_o) else $error("stray write");
    local_conn_a: assert property (rd && acc_src_i == 3'h0 && acc_addr_i == 8'h4C
        |=> acc_rdata_o[7:6] == 2'h0) else $error("local port field");
    remote_conn_a: assert property (rd && acc_src_i != 3'h0 && acc_addr_i == 8'h4C
        |=> acc_rdata_o[7:6] == 2'($past(acc_src_i) - 3'h1)) else $error("remote port field");
    // Every port, not only the one the bench drives through frames
    wire [PORTS-1:0] pass_ok;
    for (genvar p = 0; p < PORTS; p++) begin : g_pass
        assign pass_ok[p] = raw_mode_i[p] || pkt_type_o[p*6 +: 6] == video_type_i[p*6 +: 6];
    end
    csi_pass_a: assert property (&pass_ok) else $error("override in csi mode");
    cover property (rd ##1 rd);
    cover property (wr && pg && port_we_o == 4'hF);
    cover property (raw_mode_i[0] && pkt_type_o[5:0] != video_type_i[5:0]);
endmodule
bind rx_port_page_select rx_port_page_select_chk #(.PORTS(PORTS)) chk_u (.sys_clk_i, .sys_rst_i, .acc_valid_i,
    .acc_write_i, .acc_src_i, .acc_addr_i, .shared_we_o, .port_we_o, .acc_rdata_o, .acc_rvalid_o, .raw_mode_i,
    .video_type_i, .pkt_type_o);
`default_nettype wire

// file: rx_port_page_select_tb_top.sv
// Self-checking bench for the paging block
`default_nettype none
module rx_port_page_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, sys_rst_i, acc_valid_i, acc_write_i, shared_we_o, acc_rvalid_o, sw;
    logic [2:0]  acc_src_i;
    logic [7:0]  acc_addr_i, acc_wdata_i, shared_rdata_i, acc_rdata_o, rd, d, pa, old [4];
    logic [3:0]  port_we_o, raw_mode_i, frame_start_i, long_pkt_i, we, wen;
    logic [5:0]  code;
    logic [31:0] port_rdata_i;
    logic [23:0] video_type_i, pkt_type_o;
    int          n_mismatch = 0, compares = 0;
    rx_port_page_select dut_u (.sys_clk_i, .sys_rst_i, .acc_valid_i, .acc_write_i, .acc_src_i, .acc_addr_i,
        .acc_wdata_i, .shared_rdata_i, .port_rdata_i, .shared_we_o, .port_we_o, .acc_rdata_o, .acc_rvalid_o,
        .raw_mode_i, .frame_start_i, .long_pkt_i, .video_type_i, .pkt_type_o);
    page_regs_model mdl_u (.sys_clk_i, .port_we_i(port_we_o), .addr_i(acc_addr_i), .wdata_i(acc_wdata_i),
        .rdata_o(port_rdata_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [7:0] page_rst(input int s);
        return (s == 0) ? 8'h00 : {2'(s - 1), 2'(s - 1), 4'(1 << (s - 1))};
    endfunction
    task automatic test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write strobes as {shared, port 3..0}
    task automatic chk_we(input logic [4:0] got, input logic [4:0] exp);
        chk({3'h0, got}, {3'h0, exp});
    endtask
    task automatic chk_type(input logic [5:0] got, input logic [5:0] exp);
        chk({2'h0, got}, {2'h0, exp});
    endtask
    // One access; write strobes seen while taken, read data one cycle on
    task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        {acc_valid_i, acc_write_i, acc_src_i, acc_addr_i, acc_wdata_i} <= {1'b1, w, s, a, v};
        #1 we = port_we_o;
        sw = shared_we_o;
        @(posedge sys_clk_i);
        acc_valid_i <= 1'b0;
        #1 rd = acc_rdata_o;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        {acc_valid_i, acc_write_i, acc_src_i, acc_addr_i, acc_wdata_i, shared_rdata_i} = '0;
        {raw_mode_i, frame_start_i, long_pkt_i} = '0;
        sys_rst_i = 1'b1;
        void'($urandom(32'h382F));
        video_type_i = $urandom;
        for (int p = 0; p < 4; p++) old[p] = 8'(8'h61 ^ p);
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int s = 0; s < 5; s++) begin
            // Walk the end points of both paged ranges
            pa = (s % 4 == 0) ? 8'h4D : (s % 4 == 1) ? 8'h7F : (s % 4 == 2) ? 8'hD0 : 8'hDF;
            acc(3'(s), 1'b0, 8'h4C, 8'h00);
            chk(rd, page_rst(s));
            acc(3'(s), 1'b1, pa, 8'(8'hF0 ^ s));
            chk_we({sw, we}, 5'(page_rst(s) & 8'h0F));
            acc(3'(s), 1'b0, pa, 8'h00);
            chk(rd, (s == 0) ? pa : 8'(8'hF0 ^ s));
        end
        for (int i = 0; i < 6; i++) begin
            wen = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            d = $urandom;
            acc(3'h0, 1'b1, 8'h4C, {4'hC, wen});
            acc(3'h0, 1'b1, 8'h61, d);
            chk_we({sw, we}, {1'b0, wen});
            for (int p = 0; p < 4; p++) begin
                if (wen[p]) old[p] = d;
                acc(3'h0, 1'b1, 8'h4C, {2'h0, 2'(p), wen});
                acc(3'h0, 1'b0, 8'h61, 8'h00);
                chk(rd, old[p]);
                acc(3'h0, 1'b0, 8'h4C, 8'h00);
                chk(rd, {2'h0, 2'(p), wen});
                if (i == 0) acc(3'h0, 1'b0, 8'h4B, 8'h00);
                if (i == 0) chk(rd, 8'h12);
            end
            acc(3'h3, 1'b0, 8'h4C, 8'h00);
            chk(rd, page_rst(3));
            shared_rdata_i = $urandom;
            acc(3'(i % 5), 1'b0, 8'h10, 8'h00);
            chk(rd, shared_rdata_i);
            // Offsets just outside the paged ranges are shared
            acc(3'(i % 5), 1'b1, (i % 2) ? 8'h80 : 8'hCF, d);
            chk_we({sw, we}, 5'h10);
        end
        // Last pass runs a non-raw port with three override lines
        for (int n = 0; n < 5; n++) begin
            code = $urandom;
            acc(3'h0, 1'b1, 8'h4C, 8'h01);
            acc(3'h0, 1'b1, 8'h4B, {(n == 4) ? 2'h3 : 2'(n), code});
            @(posedge sys_clk_i) {raw_mode_i, frame_start_i} <= {3'h0, n < 4, 4'h1};
            @(posedge sys_clk_i) {frame_start_i, long_pkt_i} <= 8'h01;
            for (int k = 0; k < 4; k++) begin
                #1 chk_type(pkt_type_o[5:0], (k < n % 4) ? code : video_type_i[5:0]);
                @(posedge sys_clk_i);
            end
            long_pkt_i <= 4'h0;
        end
        acc(3'h0, 1'b1, 8'h4C, 8'h10);
        acc(3'h0, 1'b0, 8'h4B, 8'h00);
        chk(rd, 8'h12);
        test_done();
    end
endmodule
`default_nettype wire
